/* logic/lhm_consts.vh */
`ifndef LHM_CONSTS_VH
`define LHM_CONSTS_VH

// ------------------------------------------------------------
// Register addresses (page zero byte addresses)
// ------------------------------------------------------------
`define LHM_ADDR_LL2_MAIN    8'h2D
`define LHM_ADDR_LAMP_MAIN   8'h2E
`define LHM_ADDR_LCONV_MAIN  8'h2F
`define LHM_ADDR_RL2_MAIN    8'h30
`define LHM_ADDR_RAMP_MAIN   8'h31
`define LHM_ADDR_RCONV_MAIN  8'h32
`define LHM_ADDR_MAIN_LEVEL  8'h33
`define LHM_ADDR_LL2_COM     8'h34
`define LHM_ADDR_LAMP_COM    8'h35
`define LHM_ADDR_LCONV_COM   8'h36
`define LHM_ADDR_RL2_COM     8'h37
`define LHM_ADDR_FIRST       8'h2D
`define LHM_NUM_MIX          10

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define LHM_MIX_ROUTE_BIT    7
`define LHM_LVL_HI           7
`define LHM_LVL_LO           4
`define LHM_MUTE_OFF_BIT     3
`define LHM_PD_TRI_BIT       2
`define LHM_PEND_BIT         1
`define LHM_PWR_BIT          0

// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define LHM_MIX_RST          8'h00
`define LHM_LEVEL_RST        8'h04
`define LHM_MUTE_CODE_MIN    7'h76
`define LHM_LVL_MAX          4'h9

// ------------------------------------------------------------
// Timing: gain ramp step interval
// ------------------------------------------------------------
`define LHM_STEP_NS          40
`define LHM_CLK_NS           5
`define LHM_STEP_CYC         (`LHM_STEP_NS / `LHM_CLK_NS)

`endif

/* logic/lhm_regs.v */
// What this block does
// - Main reg 0 bit7 routes left line two
// - Main reg 1 bit7 routes left amp
// - Main reg 2 bit7 routes left converter
// - Main reg 3 bit7 routes right line two
// - Main reg 4 bit7 routes right amp
// - Main reg 5 bit7 routes right converter
// - Common reg 0 bit7 routes left line two
// - Common reg 1 bit7 routes left amp
// - Common reg 2 bit7 routes left converter
// - Common reg 3 bit7 routes right line two
// - Bits 6..0 attenuation code, reset zero
// - Level bits 7..4, 1 dB steps, reset 0
// - Bit3 set unmutes main driver, reset muted
// - Bit2 set tri-states when off, reset set
// - Bit1 reads one while gains pending
// - Bit0 set powers up main driver
// - Codes 118..127 select mute
`timescale 1ns/1ps
`default_nettype none
`include "lhm_consts.vh"

module lhm_regs (
	// Clock and reset
	input  wire        mclk,
	input  wire        rst_n,
	// Byte-wide control access
	input  wire        wr_en,
	input  wire        rd_en,
	input  wire [7:0]  addr,
	input  wire [7:0]  wr_data,
	output reg  [7:0]  rd_data,
	// Main driver mixing: routes and applied gains
	output reg  [5:0]  main_route,
	output reg  [41:0] main_gain,
	output reg  [5:0]  main_src_mute,
	// Common driver mixing
	output reg  [3:0]  com_route,
	output reg  [27:0] com_gain,
	output reg  [3:0]  com_src_mute,
	// Main driver controls
	output reg  [3:0]  main_level,
	output reg         main_unmute,
	output reg         main_pd_tristate,
	output reg         main_power_up,
	output reg         main_gain_pending
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	reg  [7:0] mix_ff [0:`LHM_NUM_MIX-1];
	reg  [7:0] level_ff;
	wire [6:0] applied_w [0:5];
	wire [5:0] diff_w;
	reg  [7:0] nxt_rd_data;
	reg  [7:0] step_cnt_ff;
	reg        pend_ff;
	wire       step_tick;
	wire       mix_hit;
	wire [7:0] mix_idx_w;
	wire [3:0] mix_idx;
	wire       any_diff;
	integer    i_w;

	// Register number decode, offsets are consecutive bytes
	assign mix_idx_w = (addr > `LHM_ADDR_MAIN_LEVEL) ? (addr - `LHM_ADDR_FIRST - 8'h01)
		: (addr - `LHM_ADDR_FIRST);
	assign mix_idx   = mix_idx_w[3:0];
	assign mix_hit   = (addr >= `LHM_ADDR_LL2_MAIN) && (addr <= `LHM_ADDR_RL2_COM)
		&& (addr != `LHM_ADDR_MAIN_LEVEL);
	assign step_tick = (step_cnt_ff == (`LHM_STEP_CYC - 1));

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	// Route bit and attenuation code stored as written
	always @(posedge mclk)
	begin
		if (!rst_n)
		begin
			for (i_w = 0; i_w < `LHM_NUM_MIX; i_w = i_w + 1)
				mix_ff[i_w] <= `LHM_MIX_RST;
			level_ff <= `LHM_LEVEL_RST;
		end
		else if (wr_en)
		begin
			if (mix_hit)
				mix_ff[mix_idx] <= wr_data;
			else if (addr == `LHM_ADDR_MAIN_LEVEL)
				// Status bit is not storage; written value dropped
				level_ff <= {wr_data[7:2], 1'b0, wr_data[0]};
		end
	end

	// ------------------------------------------------------------
	// Gain ramp toward programmed codes
	// ------------------------------------------------------------
	// Applied gains step one code per tick, avoiding zipper noise
	always @(posedge mclk)
	begin
		if (!rst_n)
			step_cnt_ff <= 8'h00;
		else if (step_tick)
			step_cnt_ff <= 8'h00;
		else
			step_cnt_ff <= step_cnt_ff + 8'h01;
	end

	// ------------------------------------------------------------
	// Ramp stages, one per main-driver source
	// ------------------------------------------------------------
	// Only the main driver reports a pending status in this bank,
	// so only its six sources ramp; common gains apply at once.
	// All stages share one tick, so a full sweep of 127 codes takes
	// roughly a thousand clocks; hosts must poll the status bit.
	lhm_gain_step #(
		.CODE_W(7)
	) u_step_ll2 (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.step_tick (step_tick),
		.target    (mix_ff[0][6:0]),
		.applied_ff(applied_w[0]),
		.differs   (diff_w[0])
	);

	lhm_gain_step #(
		.CODE_W(7)
	) u_step_lamp (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.step_tick (step_tick),
		.target    (mix_ff[1][6:0]),
		.applied_ff(applied_w[1]),
		.differs   (diff_w[1])
	);

	lhm_gain_step #(
		.CODE_W(7)
	) u_step_lconv (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.step_tick (step_tick),
		.target    (mix_ff[2][6:0]),
		.applied_ff(applied_w[2]),
		.differs   (diff_w[2])
	);

	lhm_gain_step #(
		.CODE_W(7)
	) u_step_rl2 (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.step_tick (step_tick),
		.target    (mix_ff[3][6:0]),
		.applied_ff(applied_w[3]),
		.differs   (diff_w[3])
	);

	lhm_gain_step #(
		.CODE_W(7)
	) u_step_ramp (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.step_tick (step_tick),
		.target    (mix_ff[4][6:0]),
		.applied_ff(applied_w[4]),
		.differs   (diff_w[4])
	);

	lhm_gain_step #(
		.CODE_W(7)
	) u_step_rconv (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.step_tick (step_tick),
		.target    (mix_ff[5][6:0]),
		.applied_ff(applied_w[5]),
		.differs   (diff_w[5])
	);

	// Any main-path gain not yet at its target
	assign any_diff = |diff_w;

	// ------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------
	// Status bit comes live from the pending flag, never from storage.
	// Read data holds between reads so a slow host may sample late.
	always @*
	begin
		nxt_rd_data = rd_data;
		if (rd_en)
		begin
			case (addr)
				`LHM_ADDR_LL2_MAIN:   nxt_rd_data = mix_ff[0];
				`LHM_ADDR_LAMP_MAIN:  nxt_rd_data = mix_ff[1];
				`LHM_ADDR_LCONV_MAIN: nxt_rd_data = mix_ff[2];
				`LHM_ADDR_RL2_MAIN:   nxt_rd_data = mix_ff[3];
				`LHM_ADDR_RAMP_MAIN:  nxt_rd_data = mix_ff[4];
				`LHM_ADDR_RCONV_MAIN: nxt_rd_data = mix_ff[5];
				`LHM_ADDR_MAIN_LEVEL: nxt_rd_data = {level_ff[7:2], pend_ff, level_ff[0]};
				`LHM_ADDR_LL2_COM:    nxt_rd_data = mix_ff[6];
				`LHM_ADDR_LAMP_COM:   nxt_rd_data = mix_ff[7];
				`LHM_ADDR_LCONV_COM:  nxt_rd_data = mix_ff[8];
				`LHM_ADDR_RL2_COM:    nxt_rd_data = mix_ff[9];
				default:              nxt_rd_data = 8'h00; // Unmapped reads return zero
			endcase
		end
	end

	// A main-driver gain-changing write raises pending at once, before the compare catches up
	always @(posedge mclk)
	begin
		if (!rst_n)
			pend_ff <= 1'b0;
		else if (wr_en && mix_hit && (mix_idx < 4'd6)
			&& (wr_data[6:0] != applied_w[mix_idx[2:0]]))
			pend_ff <= 1'b1;
		else
			pend_ff <= any_diff;
	end

	// ------------------------------------------------------------
	// Outputs and read data
	// ------------------------------------------------------------
	always @(posedge mclk)
	begin
		if (!rst_n)
		begin
			rd_data           <= 8'h00;
			main_route        <= 6'h00;
			main_gain         <= 42'h0;
			main_src_mute     <= 6'h00;
			com_route         <= 4'h0;
			com_gain          <= 28'h0;
			com_src_mute      <= 4'h0;
			main_level        <= 4'h0;
			main_unmute       <= 1'b0;
			main_pd_tristate  <= 1'b1;
			main_power_up     <= 1'b0;
			main_gain_pending <= 1'b0;
		end
		else
		begin
			rd_data <= nxt_rd_data;
			// Left line two into the main driver
			main_route[0]      <= mix_ff[0][`LHM_MIX_ROUTE_BIT];
			main_gain[6:0]     <= applied_w[0];
			main_src_mute[0]   <= (applied_w[0] >= `LHM_MUTE_CODE_MIN);
			// Left gain amplifier into the main driver
			main_route[1]      <= mix_ff[1][`LHM_MIX_ROUTE_BIT];
			main_gain[13:7]    <= applied_w[1];
			main_src_mute[1]   <= (applied_w[1] >= `LHM_MUTE_CODE_MIN);
			// Left converter into the main driver
			main_route[2]      <= mix_ff[2][`LHM_MIX_ROUTE_BIT];
			main_gain[20:14]   <= applied_w[2];
			main_src_mute[2]   <= (applied_w[2] >= `LHM_MUTE_CODE_MIN);
			// Right line two into the main driver
			main_route[3]      <= mix_ff[3][`LHM_MIX_ROUTE_BIT];
			main_gain[27:21]   <= applied_w[3];
			main_src_mute[3]   <= (applied_w[3] >= `LHM_MUTE_CODE_MIN);
			// Right gain amplifier into the main driver
			main_route[4]      <= mix_ff[4][`LHM_MIX_ROUTE_BIT];
			main_gain[34:28]   <= applied_w[4];
			main_src_mute[4]   <= (applied_w[4] >= `LHM_MUTE_CODE_MIN);
			// Right converter into the main driver
			main_route[5]      <= mix_ff[5][`LHM_MIX_ROUTE_BIT];
			main_gain[41:35]   <= applied_w[5];
			main_src_mute[5]   <= (applied_w[5] >= `LHM_MUTE_CODE_MIN);
			// Left line two into the common driver
			com_route[0]       <= mix_ff[6][`LHM_MIX_ROUTE_BIT];
			com_gain[6:0]      <= mix_ff[6][6:0];
			com_src_mute[0]    <= (mix_ff[6][6:0] >= `LHM_MUTE_CODE_MIN);
			// Left gain amplifier into the common driver
			com_route[1]       <= mix_ff[7][`LHM_MIX_ROUTE_BIT];
			com_gain[13:7]     <= mix_ff[7][6:0];
			com_src_mute[1]    <= (mix_ff[7][6:0] >= `LHM_MUTE_CODE_MIN);
			// Left converter into the common driver
			com_route[2]       <= mix_ff[8][`LHM_MIX_ROUTE_BIT];
			com_gain[20:14]    <= mix_ff[8][6:0];
			com_src_mute[2]    <= (mix_ff[8][6:0] >= `LHM_MUTE_CODE_MIN);
			// Right line two into the common driver
			com_route[3]       <= mix_ff[9][`LHM_MIX_ROUTE_BIT];
			com_gain[27:21]    <= mix_ff[9][6:0];
			com_src_mute[3]    <= (mix_ff[9][6:0] >= `LHM_MUTE_CODE_MIN);
			// Reserved codes are the host's duty; clamp keeps the stage sane anyway
			main_level <= (level_ff[`LHM_LVL_HI:`LHM_LVL_LO] > `LHM_LVL_MAX) ? `LHM_LVL_MAX
				: level_ff[`LHM_LVL_HI:`LHM_LVL_LO];
			main_unmute       <= level_ff[`LHM_MUTE_OFF_BIT];
			main_pd_tristate  <= level_ff[`LHM_PD_TRI_BIT];
			main_power_up     <= level_ff[`LHM_PWR_BIT];
			main_gain_pending <= pend_ff;
		end
	end

endmodule // lhm_regs

// ------------------------------------------------------------
// One analog stage: applied code walks toward its target
// ------------------------------------------------------------
// A target rewritten mid-ramp simply turns the walk around; the
// stage never jumps, which keeps clicks out of the output.
// Limitation: the walk speed is fixed by the shared tick.
module lhm_gain_step #(
	parameter CODE_W = 7
) (
	// Clock and reset
	input  wire              mclk,
	input  wire              rst_n,
	// Step strobe and programmed code
	input  wire              step_tick,
	input  wire [CODE_W-1:0] target,
	// Code now driving the stage
	output reg  [CODE_W-1:0] applied_ff,
	output reg               differs
);

	// Mismatch flag feeds the pending status of the owner
	always @*
	begin
		differs = (applied_ff != target);
	end

	// One code per tick avoids zipper noise on large changes
	always @(posedge mclk)
	begin
		if (!rst_n)
			applied_ff <= {CODE_W{1'b0}};
		else if (step_tick && (applied_ff < target))
			applied_ff <= applied_ff + {{(CODE_W-1){1'b0}}, 1'b1};
		else if (step_tick && (applied_ff > target))
			applied_ff <= applied_ff - {{(CODE_W-1){1'b0}}, 1'b1};
	end

endmodule // lhm_gain_step
`default_nettype wire

/* sim/lhm_regs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// Bank checker
// ----
module lhm_regs_monitor (
	// Access side
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [7:0]  addr,
	input wire logic [7:0]  wr_data,
	// Observed outputs
	input wire logic [7:0]  rd_data,
	input wire logic [5:0]  main_route,
	input wire logic [41:0] main_gain,
	input wire logic [3:0]  main_level,
	input wire logic        main_unmute,
	input wire logic        main_pd_tristate,
	input wire logic        main_gain_pending
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// Lone level write; outputs settle two edges on
	sequence s_lvl;
		wr_en && addr == 8'h33 ##1 !wr_en;
	endsequence
	property p_unmap; rd_en && (addr < 8'h2D || addr > 8'h37) |=> rd_data == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_hold; !rd_en |=> $stable(rd_data); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_route; wr_en && addr == 8'h2E ##1 !wr_en |=> main_route[1] == $past(wr_data[7], 2); endproperty
	a_route: assert property (p_route) else $error("route bit");
	property p_lvl;
		s_lvl |=> main_level == (($past(wr_data[7:4], 2) > 4'h9) ? 4'h9 : $past(wr_data[7:4], 2));
	endproperty
	a_lvl: assert property (p_lvl) else $error("level field");
	property p_mute; s_lvl |=> main_unmute == $past(wr_data[3], 2); endproperty
	a_mute: assert property (p_mute) else $error("mute bit");
	property p_rst; $rose(rst_n) |-> main_pd_tristate && !main_unmute && main_level == 4'h0; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	// A gain step is only taken while the status shows pending
	property p_pend; main_gain != $past(main_gain) |-> main_gain_pending; endproperty
	a_pend: assert property (p_pend) else $error("step without status");
	property p_fall; $fell(main_gain_pending) |-> $stable(main_gain); endproperty
	a_fall: assert property (p_fall) else $error("status fell early");
	c_fall: cover property ($fell(main_gain_pending));
	c_lvl: cover property (s_lvl);
	c_unmap: cover property (rd_en && addr > 8'h37);
endmodule // lhm_regs_monitor
`default_nettype wire

/* sim/lhm_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lhm_regs_tb_top;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic        rd_v = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wr_data = 8'h00;
	logic [7:0]  rd_data, sh [11], exp_q [$];
	logic [5:0]  main_route, main_src_mute, er, em;
	logic [41:0] main_gain, eg;
	logic [3:0]  com_route, com_src_mute, main_level;
	logic [27:0] com_gain;
	logic        main_unmute, main_pd_tristate, main_power_up, main_gain_pending;
	int          miscompares = 0;
	int          cmp_count = 0;
	// 200 MHz clock
	always #2.5 mclk = ~mclk;
	lhm_regs DUT (.mclk(mclk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wr_data(wr_data), .rd_data(rd_data), .main_route(main_route), .main_gain(main_gain),
		.main_src_mute(main_src_mute), .com_route(com_route), .com_gain(com_gain),
		.com_src_mute(com_src_mute), .main_level(main_level), .main_unmute(main_unmute),
		.main_pd_tristate(main_pd_tristate), .main_power_up(main_power_up),
		.main_gain_pending(main_gain_pending));
	task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
		cmp_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("FAIL %s exp %h got %h", nm, e, g);
		end
	endtask
	// One byte access; a read notes its expected byte
	task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
		@(posedge mclk);
		#1;
		{wr_en, rd_en, addr, wr_data} = {w, !w, a, d};
		if (!w)
			exp_q.push_back(d);
		@(posedge mclk);
		#1;
		{wr_en, rd_en} = 2'b00;
	endtask
	task automatic summarize();
		if (miscompares == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Read data lands one edge after the strobe
	always @(posedge mclk)
	begin
		if (rd_v)
			chk("rd_data", exp_q.pop_front(), rd_data);
		rd_v <= rd_en;
	end
	// Full ramps of six sources run in parallel, about a thousand cycles at most
	initial
	begin
		#60000;
		miscompares++;
		summarize();
	end
	initial
	begin
		void'($urandom(87));
		repeat (4) @(posedge mclk);
		#1 rst_n = 1'b1;
		for (int i = 0; i < 11; i++)
			acc(0, 8'h2D + i, (i == 6) ? 8'h04 : 8'h00);
		acc(1, 8'h38, 8'hFF);
		acc(0, 8'h38, 8'h00);
		// Random image; mute boundary codes, legal level, status bit written high
		for (int i = 0; i < 11; i++)
		begin
			sh[i] = $urandom;
			if (i < 2)
				sh[i][6:0] = 7'h76 - i;
			if (i == 6)
				sh[i] = {4'($urandom_range(9)), sh[i][3:2], 1'b1, sh[i][0]};
			acc(1, 8'h2D + i, sh[i]);
		end
		for (int n = 0; n < 8000 && main_gain_pending !== 1'b0; n++)
			@(posedge mclk);
		#1;
		chk("pending", 0, main_gain_pending);
		for (int i = 0; i < 10; i++)
		begin
			er[i % 6] = sh[i + (i > 5)][7];
			em[i % 6] = sh[i + (i > 5)][6:0] >= 7'h76;
			eg[(i % 6) * 7 +: 7] = sh[i + (i > 5)][6:0];
			if (i == 5)
				chk("main", {er, em, eg}, {main_route, main_src_mute, main_gain});
		end
		chk("com", {er[3:0], em[3:0], eg[27:0]}, {com_route, com_src_mute, com_gain});
		chk("level", sh[6] & 8'hFD,
			{main_level, main_unmute, main_pd_tristate, 1'b0, main_power_up});
		for (int i = 0; i < 11; i++)
			acc(0, 8'h2D + i, (i == 6) ? sh[i] & 8'hFD : sh[i]);
		repeat (3) @(posedge mclk);
		summarize();
	end
endmodule // lhm_regs_tb_top
bind lhm_regs lhm_regs_monitor u_mon (.mclk(mclk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en),
	.addr(addr), .wr_data(wr_data), .rd_data(rd_data), .main_route(main_route),
	.main_gain(main_gain), .main_level(main_level), .main_unmute(main_unmute),
	.main_pd_tristate(main_pd_tristate), .main_gain_pending(main_gain_pending));
`default_nettype wire
